// ===== rtl/tcrs_regs.svh
// Timing constants for the touch controller reset sequencing pair.
// Assumes a 100 MHz clock (10 ns period) on both ends.
`ifndef TCRS_REGS_SVH
`define TCRS_REGS_SVH

`define TCRS_CLK_PERIOD_NS      10
`define TCRS_RST_MIN_NS         90
`define TCRS_RST_MIN_CYC        ((`TCRS_RST_MIN_NS + `TCRS_CLK_PERIOD_NS - 1) / `TCRS_CLK_PERIOD_NS)
`define TCRS_READY_POR_MS       48
`define TCRS_READY_RST_MS       47
`define TCRS_READY_MAX_MS       70
`define TCRS_CHG_FLOAT_MS       100
`define TCRS_RAMP_CYC           16
`define TCRS_NS_PER_MS          1000000
`define TCRS_MS_TO_CYC(ms)      ((ms) * (`TCRS_NS_PER_MS / `TCRS_CLK_PERIOD_NS))
`define TCRS_CNT_W              32
`define TCRS_RST_CNT_W          8

`endif

// ===== rtl/tcrs_pkg.sv
// Types shared by the two ends of the reset sequencing link.
// Assumes the constants header is compiled alongside.
package tcrs_pkg;

    typedef enum logic [4:0] {
        DEV_OFF   = 5'b0_0001,
        DEV_HOLD  = 5'b0_0010,
        DEV_INIT  = 5'b0_0100,
        DEV_READY = 5'b0_1000,
        DEV_PEND  = 5'b1_0000
    } tcrs_dev_state_t;

    typedef enum logic [5:0] {
        HST_OFF   = 6'b00_0001,
        HST_CORE  = 6'b00_0010,
        HST_ANA   = 6'b00_0100,
        HST_HOLD  = 6'b00_1000,
        HST_WAIT  = 6'b01_0000,
        HST_READY = 6'b10_0000
    } tcrs_host_state_t;

endpackage

// ===== rtl/tcrs_link_if.sv
// Link between touch controller and its supervising host: reset line,
// supplies, message pending line. Open-drain pending line resolved here.
`timescale 1ns/100ps
interface tcrs_link_if;
    logic reset_n;
    logic core_supply;
    logic analog_supply;
    logic digital_io_supply;
    logic message_pending_n_o;
    logic message_pending_n_oe;
    logic message_pending_n;

    // Pull-up wins unless the device pulls low
    assign message_pending_n = message_pending_n_oe ? message_pending_n_o : 1'b1;

    modport device (
        input  reset_n,
        input  core_supply,
        input  analog_supply,
        input  digital_io_supply,
        input  message_pending_n,
        output message_pending_n_o,
        output message_pending_n_oe
    );

    modport host (
        output reset_n,
        output core_supply,
        output analog_supply,
        output digital_io_supply,
        input  message_pending_n
    );
endinterface

// ===== rtl/tcrs_device.sv
// Device end: power-on reset, init delay and message pending signalling.
// Assumes supply and reset levels synchronous to CLK_I.
// Notes on behaviour
// - Device boots by itself via internal POR
// - Host holds reset low during ramp
// - Host releases reset after supplies nominal
// - Core supply comes before analog supply
// - IO supply not later than core
// - Host should control supplies and reset
// - Ready 48 to 70 ms after power-up
// - Init stalls until all supplies present
// - Late analog: host recovers by command; here init just stalls until analog rises, with no command
// - Host reset pulse at least 90 ns
// - Ready 47 to 70 ms after reset
// - Reset by line, not by power removal
// - Reset held low while core off
// - After reset, assert message pending low
// - Host leaves pending line undriven meanwhile
`timescale 1ns/100ps
`include "tcrs_regs.svh"
module tcrs_device
    import tcrs_pkg::*;
#(
    parameter logic [`TCRS_CNT_W-1:0] READY_POR_CYC = `TCRS_MS_TO_CYC(`TCRS_READY_POR_MS),
    parameter logic [`TCRS_CNT_W-1:0] READY_RST_CYC = `TCRS_MS_TO_CYC(`TCRS_READY_RST_MS)
) (
    // Clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_B_I,
    // Link
    tcrs_link_if.device LINK,
    // User side
    input  wire logic MSG_ACK_I,
    output logic      READY_O,
    output logic      IN_RESET_O
);

    ////////////////////////////////////////////////////////////////////
    tcrs_dev_state_t            state;
    tcrs_dev_state_t            next_state;
    logic [`TCRS_CNT_W-1:0]     cnt;
    logic [`TCRS_CNT_W-1:0]     next_cnt;
    logic [`TCRS_CNT_W-1:0]     target;
    logic [`TCRS_CNT_W-1:0]     next_target;
    logic [`TCRS_CNT_W-1:0]     cnt_inc;
    logic                       pend_oe;
    logic                       next_pend_oe;
    logic                       ready;
    logic                       next_ready;
    logic                       in_reset;
    logic                       next_in_reset;
    logic                       supplies_ok;
    logic                       core_lost;
    logic                       held;
    logic                       init_done;

    assign supplies_ok = LINK.core_supply & LINK.analog_supply & LINK.digital_io_supply;
    assign core_lost   = ~LINK.core_supply;
    assign held        = LINK.core_supply & ~LINK.reset_n;
    assign cnt_inc     = cnt + `TCRS_CNT_W'(1);
    // Counting stalls while any supply is missing
    assign init_done   = (state == DEV_INIT) & supplies_ok & (cnt_inc >= target);

    ////////////////////////////////////////////////////////////////////
    // Sequence state; reset line and core loss override every state
    always_comb begin
        next_state = state;
        case (state)
            DEV_OFF: begin
                // Internal POR: no reset edge needed to boot
                if (LINK.core_supply) begin
                    next_state = DEV_INIT;
                end
            end
            DEV_HOLD: begin
                if (LINK.reset_n) begin
                    next_state = DEV_INIT;
                end
            end
            DEV_INIT: begin
                if (init_done) begin
                    next_state = DEV_PEND;
                end
            end
            DEV_PEND: begin
                if (MSG_ACK_I) begin
                    next_state = DEV_READY;
                end
            end
            DEV_READY: begin
                next_state = DEV_READY;
            end
            default: begin
                next_state = DEV_OFF;
            end
        endcase
        if (core_lost) begin
            next_state = DEV_OFF;
        end else if (held) begin
            next_state = DEV_HOLD;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= DEV_OFF;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Target picked on the way into init: own POR or line reset
    always_comb begin
        next_target = target;
        case (state)
            DEV_OFF: begin
                next_target = READY_POR_CYC;
            end
            DEV_HOLD: begin
                next_target = READY_RST_CYC;
            end
            default: begin
                next_target = target;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            target <= '0;
        end else begin
            target <= next_target;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Init delay counter, restarted whenever init is entered again
    always_comb begin
        next_cnt = cnt;
        case (state)
            DEV_OFF: begin
                next_cnt = '0;
            end
            DEV_HOLD: begin
                next_cnt = '0;
            end
            DEV_INIT: begin
                if (supplies_ok) begin
                    next_cnt = cnt_inc;
                end
            end
            default: begin
                next_cnt = cnt;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags follow the next state so they land with it:
    // pending never shows without ready; ready stays on in DEV_READY after pending clears
    always_comb begin
        next_pend_oe  = 1'b0;
        next_ready    = 1'b0;
        next_in_reset = 1'b1;
        case (next_state)
            DEV_PEND: begin
                next_pend_oe  = 1'b1;
                next_ready    = 1'b1;
                next_in_reset = 1'b0;
            end
            DEV_READY: begin
                next_ready    = 1'b1;
                next_in_reset = 1'b0;
            end
            default: begin
                next_pend_oe  = 1'b0;
                next_ready    = 1'b0;
                next_in_reset = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pend_oe  <= 1'b0;
            ready    <= 1'b0;
            in_reset <= 1'b1;
        end else begin
            pend_oe  <= next_pend_oe;
            ready    <= next_ready;
            in_reset <= next_in_reset;
        end
    end

    // Open-drain: only ever drives low, input (floating) otherwise
    assign LINK.message_pending_n_o  = 1'b0;
    assign LINK.message_pending_n_oe = pend_oe;
    assign READY_O                   = ready;
    assign IN_RESET_O                = in_reset;

endmodule // tcrs_device

// ===== rtl/tcrs_host.sv
// Host end: supply sequencing, reset pulses, ready wait.
// Assumes the device end sits across the link interface.
`timescale 1ns/100ps
`include "tcrs_regs.svh"
module tcrs_host
    import tcrs_pkg::*;
#(
    parameter logic [`TCRS_CNT_W-1:0] READY_WAIT_CYC = `TCRS_MS_TO_CYC(`TCRS_READY_MAX_MS),
    parameter logic [`TCRS_CNT_W-1:0] RAMP_CYC       = `TCRS_CNT_W'(`TCRS_RAMP_CYC)
) (
    // Clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_B_I,
    // User requests
    input  wire logic POWER_ON_I,
    input  wire logic HW_RESET_I,
    // Status
    output logic      COMM_OK_O,
    output logic      BUSY_O,
    // Link
    tcrs_link_if.host LINK
);

    ////////////////////////////////////////////////////////////////////
    tcrs_host_state_t           state;
    tcrs_host_state_t           next_state;
    logic [`TCRS_CNT_W-1:0]     cnt;
    logic [`TCRS_CNT_W-1:0]     next_cnt;
    logic                       rst_n;
    logic                       next_rst_n;
    logic                       core;
    logic                       next_core;
    logic                       ana;
    logic                       next_ana;
    logic                       io;
    logic                       next_io;
    logic                       ok;
    logic                       next_ok;
    logic                       busy;
    logic                       next_busy;

    always_comb begin
        next_state = state;
        next_cnt   = cnt + `TCRS_CNT_W'(1);
        next_rst_n = rst_n;
        next_core  = core;
        next_ana   = ana;
        next_io    = io;
        next_ok    = 1'b0;
        case (state)
            HST_OFF: begin
                next_rst_n = 1'b0;
                next_cnt   = '0;
                if (POWER_ON_I) begin
                    // IO with core, never after it
                    next_core  = 1'b1;
                    next_io    = 1'b1;
                    next_state = HST_CORE;
                end
            end
            HST_CORE: begin
                if (cnt >= RAMP_CYC) begin
                    next_ana   = 1'b1;
                    next_cnt   = '0;
                    next_state = HST_ANA;
                end
            end
            HST_ANA: begin
                // Release only after analog is settled, avoiding late-rise recovery
                if (cnt >= RAMP_CYC) begin
                    next_cnt   = '0;
                    next_state = HST_HOLD;
                end
            end
            HST_HOLD: begin
                next_rst_n = 1'b0;
                if (cnt + `TCRS_CNT_W'(1) >= `TCRS_CNT_W'(`TCRS_RST_MIN_CYC)) begin
                    next_rst_n = 1'b1;
                    next_cnt   = '0;
                    next_state = HST_WAIT;
                end
            end
            HST_WAIT: begin
                // Pending line is only watched, never driven
                if (!LINK.message_pending_n || cnt + `TCRS_CNT_W'(1) >= READY_WAIT_CYC) begin
                    next_ok    = 1'b1;
                    next_state = HST_READY;
                end
            end
            HST_READY: begin
                next_ok  = 1'b1;
                next_cnt = '0;
                if (HW_RESET_I) begin
                    // Reset by the line, supplies stay up
                    next_ok    = 1'b0;
                    next_rst_n = 1'b0;
                    next_state = HST_HOLD;
                end
            end
            default: begin
                next_state = HST_OFF;
            end
        endcase
        if (!POWER_ON_I) begin
            // Reset low in the same cycle as supplies drop
            next_state = HST_OFF;
            next_rst_n = 1'b0;
            next_core  = 1'b0;
            next_ana   = 1'b0;
            next_io    = 1'b0;
            next_ok    = 1'b0;
        end
        next_busy = ~next_ok;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= HST_OFF;
            cnt   <= '0;
            rst_n <= 1'b0;
            core  <= 1'b0;
            ana   <= 1'b0;
            io    <= 1'b0;
            ok    <= 1'b0;
            busy  <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            rst_n <= next_rst_n;
            core  <= next_core;
            ana   <= next_ana;
            io    <= next_io;
            ok    <= next_ok;
            busy  <= next_busy;
        end
    end

    assign LINK.reset_n           = rst_n;
    assign LINK.core_supply       = core;
    assign LINK.analog_supply     = ana;
    assign LINK.digital_io_supply = io;
    assign COMM_OK_O              = ok;
    assign BUSY_O                 = busy;

endmodule // tcrs_host

// ===== sim/tcrs_link_sva.sv
// Assertions on the reset sequencing link between host and device ends.
// Assumes link signals sampled on CLK_I, instantiated beside the interface.
`timescale 1ns/100ps
module tcrs_link_sva #(
    parameter int READY_CYC = 50
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic reset_n,
    input wire logic core_supply,
    input wire logic analog_supply,
    input wire logic digital_io_supply,
    input wire logic message_pending_n_oe,
    input wire logic message_pending_n
);
    // Exact init latency is the designer's; allow a small margin
    localparam int READY_LO = READY_CYC - 2;
    localparam int READY_HI = READY_CYC + 4;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    ////////////////////////////////////////////////////////////////////////
    // Saturates so a long idle never wraps into the window
    always_comb begin
        next_cnt = cnt;
        if (!reset_n) next_cnt = 16'h0000;
        else if (!message_pending_n_oe && cnt != 16'hffff) next_cnt = cnt + 16'h0001;
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) cnt <= 16'h0000;
        else cnt <= next_cnt;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_release;
        $rose(reset_n);
    endsequence
    sequence s_pend_up;
        ##[1:READY_HI] $rose(message_pending_n_oe);
    endsequence
    AST_RST_NOMINAL: assert property (
        reset_n |-> core_supply && analog_supply && digital_io_supply)
        else $error("reset released before supplies");
    AST_CORE_FIRST: assert property (
        $rose(analog_supply) |-> $past(core_supply)) else $error("analog before core");
    AST_ANA_RAMP: assert property (
        $rose(core_supply) |=> !analog_supply [*8]) else $error("analog too early");
    AST_IO_WITH_CORE: assert property (
        $rose(core_supply) |-> digital_io_supply) else $error("io after core");
    AST_PULSE_MIN: assert property (
        core_supply && $fell(reset_n) |=> !reset_n [*8]) else $error("reset pulse short");
    AST_CORE_OFF: assert property (
        !core_supply |-> !reset_n) else $error("reset high with core off");
    AST_INIT_STALL: assert property (
        $rose(message_pending_n_oe) |-> reset_n && core_supply && analog_supply
            && digital_io_supply && !message_pending_n) else $error("pending without supplies");
    AST_READY_DELAY: assert property (
        $rose(message_pending_n_oe) |-> cnt >= READY_LO && cnt <= READY_HI)
        else $error("ready delay off");
    AST_READY_BOUND: assert property (
        s_release |-> s_pend_up) else $error("no pending after release");
endmodule // tcrs_link_sva

// ===== sim/testbench.sv
// Testbench: host and device joined by the link, plus a lone device end.
// Assumes the design package, header and interface are compiled first.
`timescale 1ns/100ps
module testbench;
    logic       CLK_I = 1'b0;
    logic       RST_B_I = 1'b0;
    logic       power_on = 1'b0;
    logic       hw_reset = 1'b0;
    logic       msg_ack = 1'b0;
    logic       comm_prev = 1'b0;
    logic       msg_ack2 = 1'b0;
    logic       comm_ok, busy, ready, in_reset, ready2, in_reset2;
    int         waited = 0;
    int         error_cnt = 0;
    int         comparisons = 0;
    logic [7:0] exp_q[$];
    tcrs_link_if link();
    tcrs_link_if link2();
    always #5 CLK_I = ~CLK_I;
    // Shortened delays: 70 ms wait, 47 ms and 48 ms ready
    localparam logic [31:0] WAIT_CYC = 32'h0000_0050;
    localparam logic [31:0] RST_CYC  = 32'h0000_0032;
    localparam logic [31:0] POR_CYC  = 32'h0000_003c;
    ////////////////////////////////////////////////////////////////////////
    tcrs_host #(.READY_WAIT_CYC(WAIT_CYC)) i_tcrs_host (
        .CLK_I(CLK_I), .RST_B_I(RST_B_I), .POWER_ON_I(power_on), .HW_RESET_I(hw_reset),
        .COMM_OK_O(comm_ok), .BUSY_O(busy), .LINK(link.host));
    // Joined end always boots through the reset line, so only that delay matters
    tcrs_device #(.READY_RST_CYC(RST_CYC)) i_tcrs_device (
        .CLK_I(CLK_I), .RST_B_I(RST_B_I), .LINK(link.device), .MSG_ACK_I(msg_ack),
        .READY_O(ready), .IN_RESET_O(in_reset));
    // Lone end driven by the bench in the host's place, without reset pulse
    tcrs_device #(.READY_POR_CYC(POR_CYC)) i_tcrs_device_2 (
        .CLK_I(CLK_I), .RST_B_I(RST_B_I), .LINK(link2.device), .MSG_ACK_I(msg_ack2),
        .READY_O(ready2), .IN_RESET_O(in_reset2));
    tcrs_link_sva #(.READY_CYC(RST_CYC)) i_tcrs_link_sva (
        .CLK_I(CLK_I), .RST_B_I(RST_B_I), .reset_n(link.reset_n),
        .core_supply(link.core_supply), .analog_supply(link.analog_supply),
        .digital_io_supply(link.digital_io_supply),
        .message_pending_n_oe(link.message_pending_n_oe),
        .message_pending_n(link.message_pending_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_for(input int sel);
        for (int k = 0; k < 400; k++) begin
            @(negedge CLK_I);
            if ((sel == 0 ? link.reset_n : sel == 1 ? comm_ok
                : link2.message_pending_n_oe) === 1'b1) begin
                waited = k;
                return;
            end
        end
        check("wait", 8'h00, 8'h01);
    endtask
    task automatic pulse(input int sel);
        @(posedge CLK_I);
        if (sel == 0) hw_reset <= 1'b1;
        else if (sel == 1) msg_ack <= 1'b1;
        else msg_ack2 <= 1'b1;
        @(posedge CLK_I);
        hw_reset <= 1'b0;
        msg_ack <= 1'b0;
        msg_ack2 <= 1'b0;
        repeat (3) @(negedge CLK_I);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge CLK_I) begin
        if (comm_ok === 1'b1 && comm_prev !== 1'b1) begin
            if (exp_q.size() == 0) check("unexpected ready", 8'h00, 8'hff);
            else check("ready state", {ready, link.message_pending_n, in_reset, busy},
                       exp_q.pop_front());
        end
        comm_prev <= comm_ok;
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        error_cnt++;
        stop_test();
    end
    initial begin
        int w;
        {link2.reset_n, link2.core_supply, link2.analog_supply, link2.digital_io_supply} <= 4'h0;
        w = $urandom(32'h0000_18b8);
        repeat (5) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            repeat ($urandom_range(1, 9)) @(posedge CLK_I);
            power_on <= 1'b1;
            exp_q.push_back(8'h08);
            wait_for(0);
            pulse(0);
            check("refused reset", link.reset_n, 8'h01);
            wait_for(1);
            repeat ($urandom_range(1, 9)) @(posedge CLK_I);
            pulse(1);
            check("pending released", {link.message_pending_n, ready}, 8'h03);
            exp_q.push_back(8'h08);
            pulse(0);
            check("hw reset", {link.reset_n, comm_ok, in_reset}, 8'h01);
            wait_for(1);
            @(posedge CLK_I);
            power_on <= 1'b0;
            repeat (2) @(negedge CLK_I);
            check("power off", {link.core_supply, link.analog_supply,
                  link.digital_io_supply, link.reset_n, comm_ok}, 8'h00);
        end
        @(posedge CLK_I);
        {link2.reset_n, link2.core_supply, link2.digital_io_supply} <= 3'b111;
        repeat (120) @(negedge CLK_I);
        check("stalled init", {link2.message_pending_n_oe, ready2, in_reset2}, 8'h01);
        @(posedge CLK_I);
        link2.analog_supply <= 1'b1;
        wait_for(2);
        check("own power on", {ready2, link2.message_pending_n, in_reset2}, 8'h04);
        check("power-up delay", 8'(waited), 8'(POR_CYC));
        pulse(2);
        check("lone pending released", {link2.message_pending_n, ready2}, 8'h03);
        check("notes left", 8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule // testbench
